// ==== rtl/rsp_mem_if.sv ====
// Port between the pointer control and the stack entry storage
`timescale 1ns/100ps
`include "rsp_params.svh"
interface rsp_mem_if #(
    parameter int PC_W  = `RSP_PC_W,
    parameter int PTR_W = `RSP_PTR_W
);
    logic             wr_en;
    logic [PTR_W-1:0] wr_addr;
    logic [PC_W-1:0]  wr_data;
    logic [PTR_W-1:0] rd_addr;
    logic [PC_W-1:0]  rd_data;

    modport ctrl (output wr_en, output wr_addr, output wr_data, output rd_addr, input rd_data);
    modport mem  (input wr_en, input wr_addr, input wr_data, input rd_addr, output rd_data);
endinterface

// ==== rtl/rsp_params.svh ====
// Constants of the return stack pointer unit: widths, offsets, bit positions, reset values
`ifndef RSP_PARAMS_SVH
`define RSP_PARAMS_SVH

`define RSP_PC_W        21
`define RSP_PTR_W       5
`define RSP_DEPTH       31
`define RSP_ADDR_W      4
`define RSP_DATA_W      8

`define RSP_PTR_ZERO    5'h00
`define RSP_PTR_ONE     5'h01
`define RSP_PTR_MAX     5'h1f
`define RSP_PTR_LAST    5'h1e
`define RSP_PC_STEP     2

`define RSP_ADR_PTR     4'h0
`define RSP_ADR_TOP_ENTRY_LOW_BYTE    4'h1
`define RSP_ADR_TOP_ENTRY_HIGH_BYTE    4'h2
`define RSP_ADR_TOP_ENTRY_UPPER_BYTE    4'h3
`define RSP_ADR_CFG     4'h4
`define RSP_ADR_IST     4'h5
`define RSP_ADR_IMSK    4'h6

`define RSP_BIT_FULL    7
`define RSP_BIT_UNF     6
`define RSP_CFG_OVREN   0
`define RSP_CFG_RST     1'b1

`define RSP_EV_FULL     0
`define RSP_EV_UNF      1
`define RSP_EV_OVR      2
`define RSP_EV_W        3

`define RSP_BYTE_LO     0
`define RSP_BYTE_HI     8
`define RSP_BYTE_UP     16

`endif

// ==== rtl/rsp_pkg.sv ====
// Types shared by the return stack pointer unit
`include "rsp_params.svh"
package rsp_pkg;

    typedef logic [`RSP_PTR_W-1:0]  rsp_ptr_t;
    typedef logic [`RSP_DATA_W-1:0] rsp_byte_t;
    typedef logic [`RSP_EV_W-1:0]   rsp_ev_t;

    typedef enum logic [3:0]
    {
        RSP_OP_IDLE = 4'h1,
        RSP_OP_PUSH = 4'h2,
        RSP_OP_POP  = 4'h4,
        RSP_OP_SW   = 4'h8
    } rsp_op_t;

endpackage

// ==== rtl/rsp_stack_mem.sv ====
// Storage for the return stack entries, addressed one through the depth
`timescale 1ns/100ps
`include "rsp_params.svh"
module rsp_stack_mem
    import rsp_pkg::*;
#(
    parameter int PC_W  = `RSP_PC_W,
    parameter int DEPTH = `RSP_DEPTH
)(
    input wire logic clk,
    input wire logic rst,
    rsp_mem_if.mem   m
);
    typedef struct packed
    {
        logic [DEPTH:1][PC_W-1:0] ent;
    } rsp_mem_st_t;

    rsp_mem_st_t st_r;
    rsp_mem_st_t st_nxt;

    // Pointer zero names no entry, so it reads as zero
    assign m.rd_data = (m.rd_addr == `RSP_PTR_ZERO) ? '0 : st_r.ent[m.rd_addr];

    always_comb
    begin
        st_nxt = st_r;
        if (m.wr_en && (m.wr_addr != `RSP_PTR_ZERO))
        begin
            st_nxt.ent[m.wr_addr] = m.wr_data;
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            st_r <= '0;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end
endmodule

// ==== rtl/rsp_top.sv ====
// Return stack pointer unit: pointer, full and underflow flags, top-entry access, interrupt
//
// Function
// - Pointer holds values zero through thirty-one.
// - Increment before push store, decrement after pop.
// - Any reset forces the pointer to zero.
// - Software reads and overwrites the pointer value.
// - Thirty-first push without pop sets full flag.
// - Reset option: store PC+2, set full, reset.
// - No reset option: pointer sticks at thirty-one.
// - Empty pop returns zero, sets underflow flag.
// - Flags clear only by software or power-on.
// - Underflow return leaves other registers untouched.
// - Push instruction increments and stores current PC.
// - Pop instruction decrements, exposing previous entry.
// - Software writes top entry upper, high, low bytes.
// - Full bit seven, underflow six, five reads zero.
// - Pointer value sits in bits four to zero.
`timescale 1ns/100ps
`include "rsp_params.svh"
module rsp_top
    import rsp_pkg::*;
#(
    parameter int PC_W  = `RSP_PC_W,
    parameter int DEPTH = `RSP_DEPTH
)(
    input  wire logic                   MCLK,
    input  wire logic                   RESET,
    input  wire logic                   DEV_RESET,
    input  wire logic                   PUSH_REQ,
    input  wire logic                   POP_REQ,
    input  wire logic [PC_W-1:0]        PC_IN,
    output logic      [PC_W-1:0]        RET_PC,
    output logic                        RET_VALID,
    output logic                        OVF_RESET_REQ,
    input  wire logic [`RSP_ADDR_W-1:0] ADDR,
    input  wire logic [`RSP_DATA_W-1:0] WDATA,
    input  wire logic                   WR,
    input  wire logic                   RD,
    output logic      [`RSP_DATA_W-1:0] RDATA,
    output logic                        IRQ
);
    typedef struct packed
    {
        rsp_ptr_t        sp;
        logic            full;
        logic            unf;
        logic            ovr_en;
        rsp_ev_t         ist;
        rsp_ev_t         imsk;
        rsp_byte_t       rdata;
        logic [PC_W-1:0] ret_pc;
        logic            ret_valid;
        logic            ovf_req;
        logic            irq;
    } rsp_st_t;

    rsp_st_t         st_r;
    rsp_st_t         st_nxt;
    rsp_op_t         op;
    rsp_ev_t         ev;
    logic            wr_ptr;
    logic            wr_tos;
    logic            rd_ist;
    logic [PC_W-1:0] top_of_stack_entry;
    logic [PC_W-1:0] tos_mod;
    logic            wr_cfg;
    logic            wr_imsk;
    logic            tos_wr_ok;
    rsp_ptr_t        sp_inc;
    rsp_ptr_t        sp_dec;
    rsp_ev_t         ist_keep;
    rsp_byte_t       rd_mux;

    rsp_mem_if #(.PC_W(PC_W), .PTR_W(`RSP_PTR_W)) mem_if ();

    rsp_stack_mem #(
        .PC_W  (PC_W),
        .DEPTH (DEPTH)
    ) u_mem (
        .clk (MCLK),
        .rst (RESET),
        .m   (mem_if)
    );

    assign top_of_stack_entry = mem_if.rd_data;

    // The callers keep the pointer in range, so plain wrap-around arithmetic suffices
    always_comb
    begin
        sp_inc = st_r.sp + `RSP_PTR_ONE;
        sp_dec = st_r.sp - `RSP_PTR_ONE;
    end

    // Each status bit is sticky on its own; a status read clears every bit at once
    for (genvar g = 0; g < `RSP_EV_W; g++)
    begin : g_ist
        assign ist_keep[g] = st_r.ist[g] && !rd_ist;
    end

    // Register bus decode
    always_comb
    begin
        wr_ptr = WR && (ADDR == `RSP_ADR_PTR);
        wr_tos = WR && ((ADDR == `RSP_ADR_TOP_ENTRY_LOW_BYTE) ||
                        (ADDR == `RSP_ADR_TOP_ENTRY_HIGH_BYTE) ||
                        (ADDR == `RSP_ADR_TOP_ENTRY_UPPER_BYTE));
        rd_ist = RD && (ADDR == `RSP_ADR_IST);
        wr_cfg = WR && (ADDR == `RSP_ADR_CFG);
        wr_imsk = WR && (ADDR == `RSP_ADR_IMSK);
        // Pointer zero names no entry, so byte writes there go nowhere
        tos_wr_ok = wr_tos && (st_r.sp != `RSP_PTR_ZERO);
    end

    // Byte merge for software writes into the current top entry
    always_comb
    begin
        tos_mod = top_of_stack_entry;
        case (ADDR)
            `RSP_ADR_TOP_ENTRY_LOW_BYTE:
            begin
                tos_mod[`RSP_BYTE_LO +: `RSP_DATA_W] = WDATA;
            end
            `RSP_ADR_TOP_ENTRY_HIGH_BYTE:
            begin
                tos_mod[`RSP_BYTE_HI +: `RSP_DATA_W] = WDATA;
            end
            `RSP_ADR_TOP_ENTRY_UPPER_BYTE:
            begin
                tos_mod[PC_W-1:`RSP_BYTE_UP] = WDATA[PC_W-1-`RSP_BYTE_UP:0];
            end
            default:
            begin
                tos_mod = top_of_stack_entry;
            end
        endcase
    end

    // Operation select; a pointer or top-entry write in the same cycle drops the core request
    always_comb
    begin
        if (wr_ptr || wr_tos)
        begin
            op = RSP_OP_SW;
        end
        else if (PUSH_REQ)
        begin
            op = RSP_OP_PUSH;
        end
        else if (POP_REQ)
        begin
            op = RSP_OP_POP;
        end
        else
        begin
            op = RSP_OP_IDLE;
        end
    end

    // Read data mux; the register stage below gives the one-cycle read latency
    always_comb
    begin
        rd_mux = '0;
        case (ADDR)
            `RSP_ADR_PTR:
            begin
                rd_mux = {st_r.full, st_r.unf, 1'b0, st_r.sp};
            end
            `RSP_ADR_TOP_ENTRY_LOW_BYTE:
            begin
                rd_mux = top_of_stack_entry[`RSP_BYTE_LO +: `RSP_DATA_W];
            end
            `RSP_ADR_TOP_ENTRY_HIGH_BYTE:
            begin
                rd_mux = top_of_stack_entry[`RSP_BYTE_HI +: `RSP_DATA_W];
            end
            `RSP_ADR_TOP_ENTRY_UPPER_BYTE:
            begin
                rd_mux = `RSP_DATA_W'(top_of_stack_entry[PC_W-1:`RSP_BYTE_UP]);
            end
            `RSP_ADR_CFG:
            begin
                rd_mux = `RSP_DATA_W'(st_r.ovr_en);
            end
            `RSP_ADR_IST:
            begin
                rd_mux = `RSP_DATA_W'(st_r.ist);
            end
            `RSP_ADR_IMSK:
            begin
                rd_mux = `RSP_DATA_W'(st_r.imsk);
            end
            default:
            begin
                rd_mux = '0;
            end
        endcase
    end

    always_comb
    begin
        st_nxt           = st_r;
        st_nxt.ret_valid = 1'b0;
        st_nxt.ovf_req   = 1'b0;
        st_nxt.rdata     = '0;
        ev               = '0;
        mem_if.rd_addr   = st_r.sp;
        mem_if.wr_en     = 1'b0;
        mem_if.wr_addr   = sp_inc;
        mem_if.wr_data   = PC_IN;

        case (op)
            RSP_OP_SW:
            begin
                if (wr_ptr)
                begin
                    st_nxt.sp = WDATA[`RSP_PTR_W-1:0];
                    // Flag bits clear on a written zero; a one leaves them alone
                    if (!WDATA[`RSP_BIT_FULL])
                    begin
                        st_nxt.full = 1'b0;
                    end
                    if (!WDATA[`RSP_BIT_UNF])
                    begin
                        st_nxt.unf = 1'b0;
                    end
                end
                else if (tos_wr_ok)
                begin
                    mem_if.wr_en   = 1'b1;
                    mem_if.wr_addr = st_r.sp;
                    mem_if.wr_data = tos_mod;
                end
            end
            RSP_OP_PUSH:
            begin
                if (st_r.sp == `RSP_PTR_MAX)
                begin
                    // Stack already full: the last entry is kept, pointer stays
                    st_nxt.full = 1'b1;
                    ev[`RSP_EV_FULL] = 1'b1;
                end
                else if (st_r.sp == `RSP_PTR_LAST)
                begin
                    st_nxt.full = 1'b1;
                    ev[`RSP_EV_FULL] = 1'b1;
                    mem_if.wr_en = 1'b1;
                    if (st_r.ovr_en)
                    begin
                        mem_if.wr_data = PC_IN + PC_W'(`RSP_PC_STEP);
                        st_nxt.sp      = `RSP_PTR_ZERO;
                        st_nxt.ovf_req = 1'b1;
                        ev[`RSP_EV_OVR] = 1'b1;
                    end
                    else
                    begin
                        st_nxt.sp = `RSP_PTR_MAX;
                    end
                end
                else
                begin
                    mem_if.wr_en = 1'b1;
                    st_nxt.sp    = sp_inc;
                end
            end
            RSP_OP_POP:
            begin
                st_nxt.ret_valid = 1'b1;
                if (st_r.sp == `RSP_PTR_ZERO)
                begin
                    // Only the return value, the underflow flag and its status bit move; nothing is reset
                    st_nxt.ret_pc = '0;
                    st_nxt.unf    = 1'b1;
                    ev[`RSP_EV_UNF] = 1'b1;
                end
                else
                begin
                    st_nxt.ret_pc = top_of_stack_entry;
                    st_nxt.sp     = sp_dec;
                end
            end
            RSP_OP_IDLE:
            begin
                st_nxt.sp = st_r.sp;
            end
            default:
            begin
                st_nxt.sp = st_r.sp;
            end
        endcase

        // Device reset zeroes the pointer and cancels any entry store or overflow request; the flags survive it
        if (DEV_RESET)
        begin
            st_nxt.sp      = `RSP_PTR_ZERO;
            mem_if.wr_en   = 1'b0;
            st_nxt.ovf_req = 1'b0;
            // The device is already resetting, so no overflow event is raised
            ev[`RSP_EV_OVR] = 1'b0;
        end

        if (wr_cfg)
        begin
            st_nxt.ovr_en = WDATA[`RSP_CFG_OVREN];
        end
        if (wr_imsk)
        begin
            st_nxt.imsk = WDATA[`RSP_EV_W-1:0];
        end

        // An event in the same cycle as a clearing read survives it
        st_nxt.ist = ist_keep | ev;

        // Idle cycles return zero so a stale value never passes for an answer
        if (RD)
        begin
            st_nxt.rdata = rd_mux;
        end

        st_nxt.irq = |(st_nxt.ist & st_nxt.imsk);
    end

    always_ff @(posedge MCLK)
    begin
        if (RESET)
        begin
            st_r        <= '0;
            // Overflow reset comes up enabled, as software expects by default
            st_r.ovr_en <= `RSP_CFG_RST;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign RET_PC        = st_r.ret_pc;
    assign RET_VALID     = st_r.ret_valid;
    assign OVF_RESET_REQ = st_r.ovf_req;
    assign RDATA         = st_r.rdata;
    assign IRQ           = st_r.irq;
endmodule

// ==== tb/return_stack_pointer_unit_tb.sv ====
// Self-checking bench of the return stack pointer unit
`timescale 1ns/100ps
module return_stack_pointer_unit_tb
    import rsp_pkg::*;
();
    typedef struct {logic [3:0] a; logic [7:0] d; logic [7:0] e;} rsp_row_t;

    logic             MCLK  = 1'b0;
    logic             RESET = 1'b1;
    logic [3:0]       ADDR  = 4'h0;
    logic [7:0]       WDATA = 8'h00;
    logic             WR    = 1'b0;
    logic             RD    = 1'b0;
    wire logic        DEV_RESET, PUSH_REQ, POP_REQ, RET_VALID, OVF_RESET_REQ, IRQ;
    wire logic [20:0] PC_IN, RET_PC;
    wire logic [7:0]  RDATA;
    int               failures = 0;
    int               checked  = 0;
    rsp_row_t         rows [12] = '{'{4'h0, 8'h05, 8'h05}, '{4'h0, 8'hff, 8'h1f},
        '{4'h1, 8'ha5, 8'ha5}, '{4'h2, 8'h3c, 8'h3c}, '{4'h3, 8'hff, 8'h1f},
        '{4'h4, 8'h00, 8'h00}, '{4'h4, 8'h01, 8'h01}, '{4'h6, 8'h07, 8'h07},
        '{4'h7, 8'hff, 8'h00}, '{4'hf, 8'hff, 8'h00}, '{4'h0, 8'h00, 8'h00},
        '{4'h1, 8'h77, 8'h00}};

    rsp_top uut (.MCLK(MCLK), .RESET(RESET), .DEV_RESET(DEV_RESET), .PUSH_REQ(PUSH_REQ),
        .POP_REQ(POP_REQ), .PC_IN(PC_IN), .RET_PC(RET_PC), .RET_VALID(RET_VALID),
        .OVF_RESET_REQ(OVF_RESET_REQ), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
        .RDATA(RDATA), .IRQ(IRQ));
    rsp_core_model core (.clk(MCLK), .push_req(PUSH_REQ), .pop_req(POP_REQ), .pc_out(PC_IN),
        .dev_reset(DEV_RESET), .ret_pc(RET_PC), .ret_valid(RET_VALID), .ovf_req(OVF_RESET_REQ));

    always #4 MCLK = ~MCLK;

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checked++;
        if (g !== e)
        begin
            failures++;
            $display("CHECK FAILED t=%0t got %h want %h", $time, g, e);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge MCLK);
        ADDR  <= a;
        WDATA <= d;
        WR    <= 1'b1;
        @(posedge MCLK);
        WR    <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        @(posedge MCLK);
        ADDR <= a;
        RD   <= 1'b1;
        @(posedge MCLK);
        RD   <= 1'b0;
        #1 chk(RDATA, e);
    endtask

    task automatic pop_chk(input logic [31:0] e);
        core.req(1'b0, 1'b1, 21'h0);
        @(posedge MCLK);
        #1 chk(core.last_ret, e);
    endtask

    task automatic tally_and_finish();
        if (failures == 0 && checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // Generous bound: the whole sequence needs well under a thousand cycles
    initial
    begin
        repeat (20000) @(posedge MCLK);
        failures++;
        tally_and_finish();
    end

    initial
    begin
        repeat (12) @(posedge MCLK);
        RESET <= 1'b0;
        rd(4'h0, 8'h00);
        rd(4'h4, 8'h01);
        rd(4'h6, 8'h00);
        foreach (rows[i])
        begin
            wr(rows[i].a, rows[i].d);
            rd(rows[i].a, rows[i].e);
        end
        for (int i = 1; i <= 3; i++)
            core.req(1'b1, 1'b0, {i[4:0], 16'h0055});
        rd(4'h0, 8'h03);
        rd(4'h3, 8'h03);
        rd(4'h1, 8'h55);
        for (int i = 3; i >= 0; i--)
            pop_chk(i == 0 ? 32'h0 : {11'h0, i[4:0], 16'h0055});
        rd(4'h0, 8'h40);
        rd(4'h4, 8'h01);
        chk(IRQ, 1'b1);
        rd(4'h5, 8'h02);
        repeat (2) @(posedge MCLK);
        #1 chk(IRQ, 1'b0);
        wr(4'h0, 8'h42);
        core.dev_pulse();
        rd(4'h0, 8'h40);
        wr(4'h0, 8'h01);
        wr(4'h1, 8'h12);
        wr(4'h2, 8'h34);
        wr(4'h3, 8'h56);
        pop_chk(32'h163412);
        wr(4'h4, 8'h00);
        for (int i = 1; i <= 30; i++)
            core.req(1'b1, 1'b0, 21'h100 + 21'(i));
        rd(4'h0, 8'h1e);
        core.req(1'b1, 1'b0, 21'h11f);
        core.req(1'b1, 1'b0, 21'h1abcd);
        rd(4'h0, 8'h9f);
        rd(4'h1, 8'h1f);
        rd(4'h2, 8'h01);
        chk(core.ovf_cnt, 0);
        rd(4'h5, 8'h01);
        wr(4'h4, 8'h01);
        wr(4'h0, 8'h1e);
        core.req(1'b1, 1'b0, 21'h0abcd);
        rd(4'h0, 8'h80);
        chk(core.ovf_cnt, 1);
        rd(4'h5, 8'h05);
        wr(4'h0, 8'h9f);
        rd(4'h1, 8'hcf);
        rd(4'h2, 8'hab);
        @(posedge MCLK);
        RESET <= 1'b1;
        repeat (3) @(posedge MCLK);
        RESET <= 1'b0;
        rd(4'h0, 8'h00);
        fork
            wr(4'h0, 8'h02);
            core.req(1'b1, 1'b0, 21'h777);
        join
        rd(4'h0, 8'h02);
        core.req(1'b1, 1'b1, 21'h777);
        rd(4'h0, 8'h03);
        rd(4'h1, 8'h77);
        tally_and_finish();
    end
endmodule

bind rsp_top rsp_top_properties #(.PC_W(PC_W)) chk_props (.MCLK(MCLK), .RESET(RESET),
    .DEV_RESET(DEV_RESET), .PUSH_REQ(PUSH_REQ), .POP_REQ(POP_REQ), .PC_IN(PC_IN),
    .RET_PC(RET_PC), .RET_VALID(RET_VALID), .OVF_RESET_REQ(OVF_RESET_REQ), .ADDR(ADDR),
    .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .IRQ(IRQ));

// ==== tb/rsp_core_model.sv ====
// Behavioural core sequencer that pushes and pops return addresses
`timescale 1ns/100ps
module rsp_core_model
    import rsp_pkg::*;
#(
    parameter int PC_W = 21
)(
    input  wire logic            clk,
    output logic                 push_req,
    output logic                 pop_req,
    output logic [PC_W-1:0]      pc_out,
    output logic                 dev_reset,
    input  wire logic [PC_W-1:0] ret_pc,
    input  wire logic            ret_valid,
    input  wire logic            ovf_req
);
    logic [PC_W-1:0] last_ret = '0;
    logic            ovf_hold = 1'b0;
    logic            kick     = 1'b0;
    int              ovf_cnt  = 0;

    initial
    begin
        push_req = 1'b0;
        pop_req  = 1'b0;
        pc_out   = '0;
    end

    // The device resets itself in the cycle after an overflow request
    assign dev_reset = ovf_hold | kick;

    always @(posedge clk)
    begin
        if (ret_valid)
            last_ret <= ret_pc;
        if (ovf_req)
            ovf_cnt++;
        ovf_hold <= ovf_req;
    end

    task automatic req(input logic psh, input logic pp, input logic [PC_W-1:0] pc);
        @(posedge clk);
        push_req <= psh;
        pop_req  <= pp;
        pc_out   <= pc;
        @(posedge clk);
        push_req <= 1'b0;
        pop_req  <= 1'b0;
        // No stale program counter left on the lines between requests
        pc_out   <= ~pc;
    endtask

    task automatic dev_pulse();
        @(posedge clk);
        kick <= 1'b1;
        @(posedge clk);
        kick <= 1'b0;
    endtask
endmodule

// ==== tb/rsp_top_properties.sv ====
// Port-level checks of the return stack pointer unit
`timescale 1ns/100ps
module rsp_top_properties
    import rsp_pkg::*;
#(
    parameter int PC_W = 21
)(
    input wire logic            MCLK,
    input wire logic            RESET,
    input wire logic            DEV_RESET,
    input wire logic            PUSH_REQ,
    input wire logic            POP_REQ,
    input wire logic [PC_W-1:0] PC_IN,
    input wire logic [PC_W-1:0] RET_PC,
    input wire logic            RET_VALID,
    input wire logic            OVF_RESET_REQ,
    input wire logic [3:0]      ADDR,
    input wire logic [7:0]      WDATA,
    input wire logic            WR,
    input wire logic            RD,
    input wire logic [7:0]      RDATA,
    input wire logic            IRQ
);
    default clocking @(posedge MCLK); endclocking
    default disable iff (RESET);

    // A software write to indexes 0..3 swallows the core request
    wire logic pop_take  = POP_REQ && !PUSH_REQ && !(WR && ADDR < 4'h4);
    wire logic rd_ptr    = RD && ADDR == 4'h0;
    wire logic quiet     = !PUSH_REQ && !POP_REQ && !WR && !DEV_RESET;
    wire logic irq_touch = (RD && ADDR == 4'h5) || (WR && ADDR == 4'h6);

    property p_pop_answer; pop_take |=> RET_VALID; endproperty
    a_pop_answer: assert property (p_pop_answer) else $error("pop not answered");
    property p_no_answer; !pop_take |=> !RET_VALID; endproperty
    a_no_answer: assert property (p_no_answer) else $error("stray return");
    property p_ret_hold; !RET_VALID |-> $stable(RET_PC); endproperty
    a_ret_hold: assert property (p_ret_hold) else $error("return value moved");
    property p_rdata_idle; !RD |=> RDATA == 8'h00; endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data not idle");
    property p_bit5; rd_ptr |=> !RDATA[5]; endproperty
    a_bit5: assert property (p_bit5) else $error("bit five set");
    property p_devrst_ptr; DEV_RESET ##1 quiet ##1 rd_ptr |=> RDATA[4:0] == 5'h00; endproperty
    a_devrst_ptr: assert property (p_devrst_ptr) else $error("pointer kept");
    property p_ptr_write;
        (WR && ADDR == 4'h0 && !DEV_RESET) ##1 quiet ##1 rd_ptr |=>
            RDATA[4:0] == $past(WDATA[4:0], 3) && (RDATA[7:6] & ~$past(WDATA[7:6], 3)) == 2'b00;
    endproperty
    a_ptr_write: assert property (p_ptr_write) else $error("pointer write lost");
    property p_ovf_pulse; OVF_RESET_REQ |-> $past(PUSH_REQ) ##1 !OVF_RESET_REQ; endproperty
    a_ovf_pulse: assert property (p_ovf_pulse) else $error("bad overflow pulse");
    property p_irq_hold; IRQ && !irq_touch && !$past(irq_touch) |=> IRQ; endproperty
    a_irq_hold: assert property (p_irq_hold) else $error("interrupt dropped");

    c_overflow: cover property (OVF_RESET_REQ);
    c_underflow: cover property (pop_take ##1 (RET_VALID && RET_PC == '0));
    c_irq: cover property ($rose(IRQ));
endmodule
